// File: cacr_pkg.sv
package cacr_pkg;
  // Register byte addresses
  localparam logic [7:0] A_SW = 8'h07;
  localparam logic [7:0] A_PB = 8'h08;
  localparam logic [7:0] A_LIM = 8'h09;
  localparam logic [7:0] A_MON = 8'h0a;
  // Reset values; undefined reset bits are taken as zero
  localparam logic [7:0] SW_RST = 8'hfc;
  localparam logic [5:0] PB_RST = 6'h18;
  localparam logic [6:0] LIM_RST = 7'h02;
  // Field positions
  localparam int SW_EN = 7;
  localparam int SW_CODE = 2;
  localparam int SW_QUAL = 0;
  localparam int PB_W1SEL = 5;
  localparam int PB_W2SEL = 4;
  localparam int PB_REC = 3;
  localparam int PB_RTIME = 1;
  localparam int PB_PINFN = 0;
  localparam int LIM_SRST = 7;
  localparam int LIM_ILIM = 3;
  localparam int MON_TRIG = 7;
  // Output, current and lockout figures
  localparam logic [11:0] SW_BASE_MV = 12'd800;
  localparam logic [11:0] SW_STEP_MV = 12'd100;
  localparam logic [4:0] SW_MAX_CODE = 5'd25;
  localparam logic [8:0] ILIM_BASE_MA = 9'd50;
  localparam logic [8:0] ILIM_STEP_MA = 9'd50;
  localparam logic [11:0] UVLO_3P0_MV = 12'd3000;
  localparam logic [11:0] UVLO_2P8_MV = 12'd2800;
  localparam logic [11:0] UVLO_2P6_MV = 12'd2600;
  localparam logic [11:0] UVLO_2P4_MV = 12'd2400;
  localparam logic [11:0] UVLO_2P2_MV = 12'd2200;
  // Push-button times in ms, nominal values of a 20 percent window
  localparam logic [15:0] W1_SHORT_MS = 16'd80;
  localparam logic [15:0] W1_LONG_MS = 16'd600;
  localparam logic [15:0] W2_SHORT_MS = 16'd1000;
  localparam logic [15:0] W2_LONG_MS = 16'd1500;
  localparam logic [15:0] RST0_MS = 16'd5000;
  localparam logic [15:0] RST1_MS = 16'd9000;
  localparam logic [15:0] RST2_MS = 16'd11000;
  localparam logic [15:0] RST3_MS = 16'd15000;
  // Clock and millisecond tick
  localparam int CLK_NS = 4;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC = MS_NS / CLK_NS;
  // Battery monitor percent figures and codes
  localparam logic [6:0] RNG_BASE_PCT = 7'd60;
  localparam logic [6:0] RNG_STEP_PCT = 7'd10;
  localparam logic [6:0] TH_PCT1 = 7'd2;
  localparam logic [6:0] TH_PCT2 = 7'd4;
  localparam logic [6:0] TH_PCT3 = 7'd6;
  localparam logic [6:0] TH_PCT4 = 7'd8;
  localparam logic [1:0] RNG_TOP = 2'h3;
  localparam logic [2:0] TH_NONE = 3'h0;
  localparam logic [2:0] TH_C0 = 3'h1;
  localparam logic [2:0] TH_C2 = 3'h2;
  localparam logic [2:0] TH_C4 = 3'h3;
  localparam logic [2:0] TH_C6 = 3'h6;
  localparam logic [2:0] TH_C8 = 3'h7;
  // Pin idle levels {vin, button_n, ctrl, pg_n, sda, scl}
  localparam logic [5:0] PIN_IDLE = 6'h17;
  // Bus address; value is arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h2a;
endpackage : cacr_pkg

// File: cacr_mon_if.sv
// Carries the monitor request and its result
interface cacr_mon_if;
  logic start; // One-cycle request for a new reading
  logic clear; // Software reset of the result
  logic [6:0] batt_pct; // Battery as percent of regulation
  logic [1:0] range; // Result range code
  logic [2:0] thresh; // Result threshold code
  modport ctrl(output start, clear, batt_pct, input range, thresh);
  modport mon(input start, clear, batt_pct, output range, thresh);
endinterface : cacr_mon_if

// File: cacr_monitor.sv
// Range search of the voltage based battery monitor
module cacr_monitor (
  input wire logic clk_i,
  input wire logic rst_i,
  cacr_mon_if.mon mon
);
  typedef enum logic {M_IDLE = 1'b0, M_SRCH = 1'b1} cacr_mst_t;

  cacr_mst_t st_q; // Search state
  logic [1:0] try_q; // Range under test
  logic [1:0] rng_q; // Stored range result
  logic [2:0] th_q; // Stored threshold result
  logic [2:0] th_now; // Threshold code of the range under test

  // Threshold code of a reading within one range
  function automatic logic [2:0] th_code(input logic [6:0] pct, input logic [1:0] rng);
    logic [6:0] lo;
    logic [6:0] d;
    lo = 7'(cacr_pkg::RNG_BASE_PCT + cacr_pkg::RNG_STEP_PCT * 7'(rng));
    d = pct - lo;
    if (pct <= lo) return cacr_pkg::TH_NONE;
    if (d > cacr_pkg::TH_PCT4) return cacr_pkg::TH_C8;
    if (d > cacr_pkg::TH_PCT3) return cacr_pkg::TH_C6;
    if (d > cacr_pkg::TH_PCT2) return cacr_pkg::TH_C4;
    if (d > cacr_pkg::TH_PCT1) return cacr_pkg::TH_C2;
    return cacr_pkg::TH_C0;
  endfunction : th_code

  assign th_now = th_code(mon.batt_pct, try_q);
  assign mon.range = rng_q;
  assign mon.thresh = th_q;

  // One range per cycle; a new request restarts the search
  always_ff @(posedge clk_i) begin
    if (rst_i || mon.clear) begin
      st_q <= M_IDLE;
      try_q <= 2'h0;
      rng_q <= 2'h0;
      th_q <= 3'h0;
    end else if (mon.start) begin
      st_q <= M_SRCH;
      try_q <= cacr_pkg::RNG_TOP;
    end else begin
      case (st_q)
        M_SRCH: begin
          if (th_now != cacr_pkg::TH_NONE) begin
            st_q <= M_IDLE;
            rng_q <= try_q;
            th_q <= th_now;
          end else if (try_q == 2'h0) begin
            st_q <= M_IDLE;
            rng_q <= 2'h0;
            th_q <= cacr_pkg::TH_NONE;
          end else begin
            try_q <= try_q - 2'h1;
          end
        end
        default: st_q <= M_IDLE;
      endcase
    end
  end
endmodule : cacr_monitor

// File: cacr_top.sv
// Auxiliary control registers reached over the I2C pins
module cacr_top #(
  parameter logic [6:0] DEV_ADDR = cacr_pkg::DEV_ADDR,
  parameter int MS_CYC = cacr_pkg::MS_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic switch_control_pin_i,
  input wire logic pushbutton_input_n_i,
  input wire logic vin_valid_i,
  input wire logic power_good_n_i,
  input wire logic low_power_req_i,
  input wire logic [6:0] batt_pct_i,
  output logic switch_enable_o,
  output logic [4:0] switch_output_code_o,
  output logic switch_pass_through_o,
  output logic [11:0] switch_target_mv_o,
  output logic [8:0] input_current_ma_o,
  output logic [11:0] battery_lockout_mv_o,
  output logic shared_pin_o,
  output logic pb_reset_o,
  output logic ship_mode_o,
  output logic hiz_mode_o
);
  // Bus states, Gray coded along the usual path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_AACK = 3'h3,
    ST_WR = 3'h2,
    ST_WACK = 3'h6,
    ST_RD = 3'h7,
    ST_RACK = 3'h5
  } cacr_i2c_t;

  localparam int TW = $clog2(MS_CYC + 1);

  // Pin synchroniser chain and filtered levels
  logic [5:0] raw;
  logic [5:0] s1_q;
  logic [5:0] s2_q;
  logic [5:0] s3_q;
  logic [5:0] pin_q;
  logic [1:0] prev_q; // Last filtered {sda, scl}

  logic scl;
  logic sda;
  logic pb_n;
  logic ctrl;
  logic vin_ok;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;

  // Bus engine state
  cacr_i2c_t st_q;
  logic [3:0] cnt_q; // Bit count within a byte
  logic [7:0] sh_q; // Receive shifter
  logic [7:0] tx_q; // Transmit shifter
  logic [7:0] ptr_q; // Register pointer
  logic rw_q; // Read when set
  logic first_q; // Next written byte is the pointer
  logic ack_q; // Host acknowledged the last byte
  logic oe_q; // Pulls SDA low when set
  logic wr_stb_q; // One-cycle register write
  logic [7:0] wr_addr_q;
  logic [7:0] wr_dat_q;
  logic rd_clr_q; // Button register has been read
  logic [7:0] rd_data;

  // Register contents
  logic [7:0] sw_q; // Switch control, bit 1 unused
  logic [5:0] pb_q; // Button control bits 7 to 2
  logic [6:0] lim_q; // Current limit and lockout bits 6 to 0
  logic w1_q; // First wake status
  logic w2_q; // Second wake status
  logic srst; // Software reset strobe
  logic mon_start_q;

  // Button timing
  logic [TW-1:0] tick_q;
  logic tick;
  logic [15:0] hold_q; // Whole ms held
  logic fired_q; // Reset already sent this press
  logic w1_hit;
  logic w2_hit;
  logic rst_hit;
  logic [15:0] w1_ms;
  logic [15:0] w2_ms;
  logic [15:0] rst_ms;

  cacr_mon_if mon_if();

  cacr_monitor u_mon (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .mon(mon_if.mon)
  );

  // Switch output level in mV
  function automatic logic [11:0] sw_mv(input logic [4:0] code);
    return 12'(cacr_pkg::SW_BASE_MV + cacr_pkg::SW_STEP_MV * 12'(code));
  endfunction : sw_mv

  // Lockout level in mV, zero for reserved codes
  function automatic logic [11:0] uvlo_mv(input logic [2:0] code);
    case (code)
      3'h2: return cacr_pkg::UVLO_3P0_MV;
      3'h3: return cacr_pkg::UVLO_2P8_MV;
      3'h4: return cacr_pkg::UVLO_2P6_MV;
      3'h5: return cacr_pkg::UVLO_2P4_MV;
      3'h6: return cacr_pkg::UVLO_2P2_MV;
      3'h7: return cacr_pkg::UVLO_2P2_MV;
      default: return 12'h000;
    endcase
  endfunction : uvlo_mv

  assign raw = {vin_valid_i, pushbutton_input_n_i, switch_control_pin_i,
                power_good_n_i, sda_i, scl_i};

  // Three stages; a level counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= cacr_pkg::PIN_IDLE;
      s2_q <= cacr_pkg::PIN_IDLE;
      s3_q <= cacr_pkg::PIN_IDLE;
      pin_q <= cacr_pkg::PIN_IDLE;
      prev_q <= 2'h3;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      pin_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & pin_q);
      prev_q <= pin_q[1:0];
    end
  end

  assign scl = pin_q[0];
  assign sda = pin_q[1];
  assign ctrl = pin_q[3];
  assign pb_n = pin_q[4];
  assign vin_ok = pin_q[5];
  assign scl_rise = scl & ~prev_q[0];
  assign scl_fall = ~scl & prev_q[0];
  // Start and stop are SDA edges while SCL stays high
  assign start = scl & prev_q[0] & prev_q[1] & ~sda;
  assign stop = scl & prev_q[0] & ~prev_q[1] & sda;

  // Read view; trigger and software reset read as zero
  always_comb begin
    case (ptr_q)
      cacr_pkg::A_SW: rd_data = {sw_q[7:2], 1'b0, sw_q[0]};
      cacr_pkg::A_PB: rd_data = {pb_q, w1_q, w2_q};
      cacr_pkg::A_LIM: rd_data = {1'b0, lim_q};
      cacr_pkg::A_MON: rd_data = {1'b0, mon_if.range, mon_if.thresh, 2'h0};
      default: rd_data = 8'h00; // Unmapped reads as zero
    endcase
  end

  // Bus engine: acts on filtered SCL edges, starts and stops only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      ack_q <= 1'b0;
      oe_q <= 1'b0;
      wr_stb_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_dat_q <= 8'h00;
      rd_clr_q <= 1'b0;
    end else begin
      wr_stb_q <= 1'b0;
      rd_clr_q <= 1'b0;
      if (start) begin
        // Repeated start is taken in any state
        st_q <= ST_ADDR;
        cnt_q <= 4'h0;
        oe_q <= 1'b0;
      end else if (stop) begin
        st_q <= ST_IDLE;
        oe_q <= 1'b0;
      end else begin
        case (st_q)
          ST_IDLE: oe_q <= 1'b0;
          ST_ADDR: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == 4'h8) begin
              if (sh_q[7:1] == DEV_ADDR) begin
                st_q <= ST_AACK;
                oe_q <= 1'b1;
                rw_q <= sh_q[0];
                first_q <= 1'b1;
              end else begin
                st_q <= ST_IDLE; // Other address: stay off the bus
              end
            end
          end
          ST_AACK: begin
            if (scl_fall) begin
              cnt_q <= 4'h0;
              if (rw_q) begin
                st_q <= ST_RD;
                tx_q <= rd_data;
                oe_q <= ~rd_data[7];
                ptr_q <= ptr_q + 8'h01;
                rd_clr_q <= (ptr_q == cacr_pkg::A_PB);
              end else begin
                st_q <= ST_WR;
                oe_q <= 1'b0;
              end
            end
          end
          ST_WR: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda};
              cnt_q <= cnt_q + 4'h1;
            end else if (scl_fall && cnt_q == 4'h8) begin
              st_q <= ST_WACK;
              oe_q <= 1'b1;
              first_q <= 1'b0;
              if (first_q) begin
                ptr_q <= sh_q;
              end else begin
                wr_stb_q <= 1'b1;
                wr_addr_q <= ptr_q;
                wr_dat_q <= sh_q;
                ptr_q <= ptr_q + 8'h01;
              end
            end
          end
          ST_WACK: begin
            if (scl_fall) begin
              st_q <= ST_WR;
              oe_q <= 1'b0;
              cnt_q <= 4'h0;
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              if (cnt_q == 4'h7) begin
                st_q <= ST_RACK;
                oe_q <= 1'b0;
              end else begin
                oe_q <= ~tx_q[6];
                tx_q <= {tx_q[6:0], 1'b0};
                cnt_q <= cnt_q + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              ack_q <= ~sda;
            end else if (scl_fall) begin
              cnt_q <= 4'h0;
              if (ack_q) begin
                st_q <= ST_RD;
                tx_q <= rd_data;
                oe_q <= ~rd_data[7];
                ptr_q <= ptr_q + 8'h01;
                rd_clr_q <= (ptr_q == cacr_pkg::A_PB);
              end else begin
                st_q <= ST_IDLE; // Host ended the read
              end
            end
          end
          default: st_q <= ST_IDLE;
        endcase
      end
    end
  end

  assign srst = wr_stb_q && wr_addr_q == cacr_pkg::A_LIM && wr_dat_q[cacr_pkg::LIM_SRST];

  // Switch control register
  always_ff @(posedge clk_i) begin
    if (rst_i || srst) begin
      sw_q <= cacr_pkg::SW_RST;
    end else if (wr_stb_q && wr_addr_q == cacr_pkg::A_SW) begin
      sw_q[cacr_pkg::SW_EN] <= wr_dat_q[cacr_pkg::SW_EN];
      sw_q[cacr_pkg::SW_QUAL] <= wr_dat_q[cacr_pkg::SW_QUAL];
      // Code is dropped unless both the bit and the pin hold it off
      if (!sw_q[cacr_pkg::SW_EN] && !ctrl) begin
        sw_q[cacr_pkg::SW_CODE +: 5] <= wr_dat_q[cacr_pkg::SW_CODE +: 5];
      end
    end
  end

  // Button control and limit registers
  always_ff @(posedge clk_i) begin
    if (rst_i || srst) begin
      pb_q <= cacr_pkg::PB_RST;
      lim_q <= cacr_pkg::LIM_RST;
    end else if (wr_stb_q) begin
      if (wr_addr_q == cacr_pkg::A_PB) begin
        pb_q <= wr_dat_q[7:2];
      end
      if (wr_addr_q == cacr_pkg::A_LIM) begin
        lim_q <= wr_dat_q[6:0];
      end
    end
  end

  // Wake status: a new event wins over a read clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      w1_q <= 1'b0;
      w2_q <= 1'b0;
    end else begin
      w1_q <= w1_hit | (w1_q & ~rd_clr_q & ~srst);
      w2_q <= w2_hit | (w2_q & ~rd_clr_q & ~srst);
    end
  end

  // Thresholds picked by the select fields
  assign w1_ms = pb_q[cacr_pkg::PB_W1SEL] ? cacr_pkg::W1_LONG_MS : cacr_pkg::W1_SHORT_MS;
  assign w2_ms = pb_q[cacr_pkg::PB_W2SEL] ? cacr_pkg::W2_LONG_MS : cacr_pkg::W2_SHORT_MS;
  always_comb begin
    case (pb_q[cacr_pkg::PB_RTIME +: 2])
      2'h0: rst_ms = cacr_pkg::RST0_MS;
      2'h1: rst_ms = cacr_pkg::RST1_MS;
      2'h2: rst_ms = cacr_pkg::RST2_MS;
      default: rst_ms = cacr_pkg::RST3_MS;
    endcase
  end

  // Millisecond tick, restarted on every press
  always_ff @(posedge clk_i) begin
    if (rst_i || pb_n) begin
      tick_q <= '0;
    end else if (tick) begin
      tick_q <= '0;
    end else begin
      tick_q <= tick_q + 1'b1;
    end
  end

  assign tick = ~pb_n && tick_q == TW'(MS_CYC - 1);

  // Hold time; saturates so a stuck button cannot wrap
  always_ff @(posedge clk_i) begin
    if (rst_i || pb_n) begin
      hold_q <= 16'h0000;
      fired_q <= 1'b0;
    end else begin
      if (tick && hold_q != 16'hffff) begin
        hold_q <= hold_q + 16'h0001;
      end
      if (rst_hit) begin
        fired_q <= 1'b1;
      end
    end
  end

  // Each crossing is seen once per press
  assign w1_hit = tick && hold_q == w1_ms;
  assign w2_hit = tick && hold_q == w2_ms;
  // Qualified reset may fire late, once the input becomes valid
  assign rst_hit = ~pb_n && !fired_q && hold_q >= rst_ms &&
                   (!sw_q[cacr_pkg::SW_QUAL] || vin_ok);

  // Monitor runs on trigger writes, before low-power entry and on button resets
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mon_start_q <= 1'b0;
    end else begin
      mon_start_q <= (wr_stb_q && wr_addr_q == cacr_pkg::A_MON &&
                      wr_dat_q[cacr_pkg::MON_TRIG]) || low_power_req_i || rst_hit;
    end
  end

  assign mon_if.start = mon_start_q;
  assign mon_if.clear = srst;
  assign mon_if.batt_pct = batt_pct_i;

  // Registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
      switch_enable_o <= 1'b0;
      switch_output_code_o <= 5'h00;
      switch_pass_through_o <= 1'b0;
      switch_target_mv_o <= 12'h000;
      input_current_ma_o <= 9'h000;
      battery_lockout_mv_o <= 12'h000;
      shared_pin_o <= 1'b1;
      pb_reset_o <= 1'b0;
      ship_mode_o <= 1'b0;
      hiz_mode_o <= 1'b0;
    end else begin
      sda_o <= 1'b0; // Open drain: only ever pulls low
      sda_oe_o <= oe_q;
      switch_enable_o <= sw_q[cacr_pkg::SW_EN] & ctrl;
      switch_output_code_o <= sw_q[cacr_pkg::SW_CODE +: 5];
      switch_pass_through_o <= sw_q[cacr_pkg::SW_CODE +: 5] > cacr_pkg::SW_MAX_CODE;
      switch_target_mv_o <= sw_mv(sw_q[cacr_pkg::SW_CODE +: 5]);
      input_current_ma_o <= 9'(cacr_pkg::ILIM_BASE_MA +
                               cacr_pkg::ILIM_STEP_MA * 9'(lim_q[cacr_pkg::LIM_ILIM +: 3]));
      battery_lockout_mv_o <= uvlo_mv(lim_q[2:0]);
      shared_pin_o <= pb_q[cacr_pkg::PB_PINFN] ? pb_n : pin_q[2];
      pb_reset_o <= rst_hit;
      ship_mode_o <= rst_hit & ~pb_q[cacr_pkg::PB_REC];
      hiz_mode_o <= rst_hit & pb_q[cacr_pkg::PB_REC];
    end
  end
endmodule : cacr_top

// File: cacr_i2c_host.sv
// Bus master model; the clock is low 13 and high 10 system clocks
module cacr_i2c_host (
  input wire logic clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Released lines idle high
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic hw(input int n);
    repeat (n) @(posedge clk_i);
  endtask : hw
  // Data moves mid low phase, so the slave's late release still meets setup
  task automatic bit_x(input logic b, output logic r);
    hw(5);
    sda_o <= b;
    hw(8);
    scl_o <= 1'b1;
    hw(5);
    #1 r = sda_i;
    hw(5);
    scl_o <= 1'b0;
  endtask : bit_x
  // Start, or repeated start from a low clock
  task automatic start;
    hw(10);
    sda_o <= 1'b1;
    hw(5);
    scl_o <= 1'b1;
    hw(10);
    sda_o <= 1'b0;
    hw(10);
    scl_o <= 1'b0;
  endtask : start
  task automatic stop;
    hw(5);
    sda_o <= 1'b0;
    hw(5);
    scl_o <= 1'b1;
    hw(10);
    sda_o <= 1'b1;
    hw(10);
  endtask : stop
  // Eight bits MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic ab, output logic [7:0] q,
                      output logic ak);
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(ab, ak);
  endtask : xfer
endmodule : cacr_i2c_host

// File: cacr_chk_monitor.sv
// Port watcher; outputs lag reset release, so value checks wait a few edges
module cacr_chk #(
  parameter int MS_CYC = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pushbutton_input_n_i,
  input wire logic switch_enable_o,
  input wire logic [4:0] switch_output_code_o,
  input wire logic switch_pass_through_o,
  input wire logic [11:0] switch_target_mv_o,
  input wire logic [8:0] input_current_ma_o,
  input wire logic [11:0] battery_lockout_mv_o,
  input wire logic pb_reset_o,
  input wire logic ship_mode_o,
  input wire logic hiz_mode_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [1:0] up_q; // Edges since release, saturating
  int held_q; // Raw pin leads its synced copy, so this bounds the hold
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      up_q <= 2'h0;
    end else if (up_q != 2'h3) begin
      up_q <= up_q + 2'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || pushbutton_input_n_i) begin
      held_q <= 0;
    end else begin
      held_q <= held_q + 1;
    end
  end
  target_mv_a: assert property (up_q == 2'h3 |->
    switch_target_mv_o == 12'(800 + 100 * switch_output_code_o)) else $error("bad target");
  pass_thru_a: assert property (up_q == 2'h3 |->
    switch_pass_through_o == (switch_output_code_o > 5'h19)) else $error("bad pass");
  code_lock_a: assert property (up_q == 2'h3 && $changed(switch_output_code_o) &&
    switch_output_code_o != 5'h1f |-> !$past(switch_enable_o)) else $error("code moved");
  current_a: assert property (up_q == 2'h3 |-> input_current_ma_o % 50 == 0 &&
    input_current_ma_o inside {[50:400]}) else $error("bad current");
  lockout_a: assert property (up_q == 2'h3 |-> battery_lockout_mv_o inside
    {0, 2200, 2400, 2600, 2800, 3000}) else $error("bad lockout");
  reset_pulse_a: assert property (pb_reset_o |=> !pb_reset_o) else $error("long pulse");
  hold_time_a: assert property (pb_reset_o |-> held_q >= 5000 * MS_CYC)
    else $error("early reset");
  mode_pick_a: assert property (pb_reset_o |-> ship_mode_o != hiz_mode_o)
    else $error("bad mode");
  mode_cause_a: assert property (ship_mode_o || hiz_mode_o |-> pb_reset_o)
    else $error("stray mode");
  cover property (pb_reset_o && ship_mode_o);
  cover property (pb_reset_o && hiz_mode_o);
  cover property ($fell(switch_pass_through_o));
endmodule : cacr_chk

bind cacr_top cacr_chk #(.MS_CYC(MS_CYC)) u_chk (.clk_i, .rst_i, .pushbutton_input_n_i,
  .switch_enable_o, .switch_output_code_o, .switch_pass_through_o, .switch_target_mv_o,
  .input_current_ma_o, .battery_lockout_mv_o, .pb_reset_o, .ship_mode_o, .hiz_mode_o);

// File: cacr_top_tb.sv
module cacr_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 2; // Short millisecond keeps the hold times affordable
  logic clk_i, rst_i, scl_i, sda_i, sda_o, sda_oe_o, h_sda, low_power_req_i;
  logic switch_control_pin_i, pushbutton_input_n_i, vin_valid_i, power_good_n_i;
  logic switch_enable_o, switch_pass_through_o, pb_reset_o, ship_mode_o, hiz_mode_o;
  logic shared_pin_o;
  logic [6:0] batt_pct_i;
  logic [4:0] switch_output_code_o;
  logic [11:0] switch_target_mv_o, battery_lockout_mv_o;
  logic [8:0] input_current_ma_o;
  int num_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  // Open-drain data line with a pull-up
  assign sda_i = h_sda & (sda_oe_o ? sda_o : 1'b1);
  cacr_top #(.MS_CYC(MS)) u_dut (.clk_i, .rst_i, .scl_i, .sda_i, .sda_o, .sda_oe_o,
    .switch_control_pin_i, .pushbutton_input_n_i, .vin_valid_i, .power_good_n_i,
    .low_power_req_i, .batt_pct_i, .switch_enable_o, .switch_output_code_o,
    .switch_pass_through_o, .switch_target_mv_o, .input_current_ma_o,
    .battery_lockout_mv_o, .shared_pin_o, .pb_reset_o, .ship_mode_o, .hiz_mode_o);
  cacr_i2c_host u_host (.clk_i, .sda_i, .scl_o(scl_i), .sda_o(h_sda));
  task automatic end_of_test;
    if (num_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] s);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One byte whose slot must be acknowledged by the slave
  task automatic xb(input logic [7:0] d);
    logic [7:0] q;
    logic k;
    u_host.xfer(d, 1'b1, q, k);
    chk("ack", 12'h000, {11'h0, k});
  endtask : xb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.start();
    xb({cacr_pkg::DEV_ADDR, 1'b0});
    xb(a);
    xb(d);
    u_host.stop();
  endtask : wr
  // Pointer write, repeated start, one byte read closed by a NACK
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic k;
    u_host.start();
    xb({cacr_pkg::DEV_ADDR, 1'b0});
    xb(a);
    u_host.start();
    xb({cacr_pkg::DEV_ADDR, 1'b1});
    u_host.xfer(8'hff, 1'b1, d, k);
    u_host.stop();
    chk("reg", {4'h0, e}, {4'h0, d});
  endtask : rchk
  // Pulses are sampled mid-cycle so the edge race cannot hide them
  task automatic wpr(input int n, output int c);
    c = 0;
    while (c < n && pb_reset_o !== 1'b1) begin
      @(negedge clk_i);
      c++;
    end
  endtask : wpr
  task automatic t_regs;
    rchk(8'h07, 8'hfc);
    rchk(8'h08, 8'h60);
    rchk(8'h09, 8'h02);
    rchk(8'h0a, 8'h00);
    rchk(8'h0c, 8'h00);
  endtask : t_regs
  task automatic t_code;
    logic [4:0] c;
    wr(8'h07, 8'h00);
    chk("code", 12'h01f, {7'h0, switch_output_code_o});
    for (int i = 0; i < 4; i++) begin
      c = (i == 3) ? 5'h00 : 5'(24 + i);
      wr(8'h07, {1'b0, c, 2'b00});
      chk("mv", 12'(800 + 100 * c), switch_target_mv_o);
      chk("pass", {11'h0, c > 5'h19}, {11'h0, switch_pass_through_o});
    end
    switch_control_pin_i <= 1'b1;
    wr(8'h07, 8'h94);
    chk("code", 12'h000, {7'h0, switch_output_code_o});
    chk("en", 12'h001, {11'h0, switch_enable_o});
    switch_control_pin_i <= 1'b0;
  endtask : t_code
  task automatic t_lim;
    for (int k = 0; k < 8; k++) begin
      wr(8'h09, {2'b00, 3'(k), 3'(k)});
      chk("ma", 12'(50 + 50 * k), {3'h0, input_current_ma_o});
      chk("uvlo", (k < 2) ? 12'h000 : (k > 5) ? 12'h898 : 12'(3000 - 200 * (k - 2)),
          battery_lockout_mv_o);
    end
  endtask : t_lim
  task automatic t_pin;
    wr(8'h08, 8'h00);
    power_good_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk("pin", 12'h000, {11'h0, shared_pin_o});
    wr(8'h08, 8'h04);
    chk("pin", 12'h001, {11'h0, shared_pin_o});
    pushbutton_input_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk("pin", 12'h000, {11'h0, shared_pin_o});
    pushbutton_input_n_i <= 1'b1;
    power_good_n_i <= 1'b1;
  endtask : t_pin
  task automatic t_press;
    int c;
    time tp;
    wr(8'h08, 8'h00);
    pushbutton_input_n_i <= 1'b0;
    tp = $time;
    repeat (200) @(posedge clk_i);
    rchk(8'h08, 8'h02);
    repeat (1400) @(posedge clk_i);
    rchk(8'h08, 8'h01);
    rchk(8'h08, 8'h00);
    wpr(12000, c);
    c = int'(($time - tp) / 4);
    chk("hold", 12'h001, {11'h0, c >= 5000 * MS && c <= 5000 * MS + 12});
    chk("ship", 12'h001, {11'h0, ship_mode_o & ~hiz_mode_o});
    @(posedge clk_i);
    pushbutton_input_n_i <= 1'b1;
    wr(8'h07, 8'h01);
    wr(8'h08, 8'he8);
    pushbutton_input_n_i <= 1'b0;
    repeat (400) @(posedge clk_i);
    rchk(8'h08, 8'he8);
    repeat (2200) @(posedge clk_i);
    rchk(8'h08, 8'heb);
    wpr(15000, c);
    chk("norst", 12'h000, {11'h0, pb_reset_o});
    @(posedge clk_i);
    vin_valid_i <= 1'b1;
    wpr(12, c);
    chk("hiz", 12'h001, {11'h0, hiz_mode_o & pb_reset_o});
    @(posedge clk_i);
    pushbutton_input_n_i <= 1'b1;
  endtask : t_press
  task automatic t_mon;
    logic [6:0] p [6] = '{7'h5f, 7'h51, 7'h57, 7'h3f, 7'h46, 7'h32};
    logic [7:0] e [6] = '{8'h6c, 8'h44, 8'h58, 8'h08, 8'h1c, 8'h00};
    for (int i = 0; i < 6; i++) begin
      batt_pct_i <= p[i];
      wr(8'h0a, 8'h80);
      rchk(8'h0a, e[i]);
    end
    batt_pct_i <= 7'h5f;
    low_power_req_i <= 1'b1;
    @(posedge clk_i);
    low_power_req_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    rchk(8'h0a, 8'h6c);
    wr(8'h09, 8'h80);
    t_regs();
  endtask : t_mon
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // Hang guard, well above the expected run of about 63000 cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 100000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    rst_i = 1'b1;
    switch_control_pin_i = 1'b0;
    pushbutton_input_n_i = 1'b1;
    vin_valid_i = 1'b0;
    power_good_n_i = 1'b1;
    low_power_req_i = 1'b0;
    batt_pct_i = 7'h00;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    t_regs();
    t_code();
    t_lim();
    t_pin();
    t_press();
    t_mon();
    end_of_test();
  end
endmodule : cacr_top_tb
